// ### src/pmac_consts.svh
`ifndef PMAC_CONSTS_SVH
`define PMAC_CONSTS_SVH

// Region table limits
`define PMAC_MAX_REGIONS   16
`define PMAC_ADDR_PAD      2'h0

// Exception codes returned with a fault
`define PMAC_CAUSE_NONE    5'h00
`define PMAC_CAUSE_INSTR   5'h01
`define PMAC_CAUSE_LOAD    5'h05
`define PMAC_CAUSE_STORE   5'h07

// Memory type bit positions
`define PMAC_MT_BUF        0
`define PMAC_MT_CACHE      1

// Attribute sets {main, bufferable, cacheable, atomic}
`define PMAC_ATTR_NOREGION 4'h9
`define PMAC_ATTR_UNMAPPED 4'h0

// Register byte offsets
`define PMAC_OFS_CAUSE     5'h00
`define PMAC_OFS_FADDR     5'h04
`define PMAC_OFS_COUNT     5'h08
`define PMAC_OFS_PROBE     5'h0c
`define PMAC_OFS_PATTR     5'h10

// Field positions and reset values
`define PMAC_CAUSE_VLD_BIT 8
`define PMAC_COUNT_W       16
`define PMAC_RST_WORD      32'h0000_0000

`endif

// ### src/pmac_pkg.sv
package pmac_pkg;

	// One region entry
	typedef struct packed {
		logic [31:0] wordAddrLow;
		logic [31:0] wordAddrHigh;
		logic        main;
		logic        bufferable;
		logic        cacheable;
		logic        atomic;
	} pmac_region_type;

	// Attributes resolved for one address
	typedef struct packed {
		logic main;
		logic bufferable;
		logic cacheable;
		logic atomic;
	} pmac_attr_type;

	typedef enum logic [1:0] {
		PMAC_SZ_BYTE = 2'b00,
		PMAC_SZ_HALF = 2'b01,
		PMAC_SZ_WORD = 2'b10
	} pmac_size_type;

	typedef enum logic [1:0] {
		PMAC_AT_NONE = 2'b00,
		PMAC_AT_LR   = 2'b01,
		PMAC_AT_SC   = 2'b10,
		PMAC_AT_AMO  = 2'b11
	} pmac_atom_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} pmac_fetch_req_type;

	typedef struct packed {
		logic       valid;
		logic       fault;
		logic [4:0] cause;
	} pmac_fetch_rsp_type;

	typedef struct packed {
		logic          valid;
		logic [31:0]   addr;
		logic          write;
		pmac_size_type size;
		pmac_atom_type atom;
		logic          stack;
		logic          modifiable;
		logic          speculative;
	} pmac_lsu_req_type;

	typedef struct packed {
		logic       valid;
		logic       fault;
		logic [4:0] cause;
		logic [1:0] memType;
		logic       writeBuf;
		logic       hold;
	} pmac_lsu_rsp_type;

	typedef struct packed {
		pmac_fetch_rsp_type fetchRsp;
		pmac_lsu_rsp_type   lsuRsp;
		logic               waitReq;
		logic [31:0]        readData;
		logic               faultValid;
		logic [4:0]         faultCause;
		logic [31:0]        faultAddr;
		logic [15:0]        faultCount;
		logic [31:0]        probeAddr;
	} pmac_state_type;

endpackage

// ### src/pmac_check.sv
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "pmac_consts.svh"
// Functional notes
// - Region count parameter, zero to sixteen
// - Entry: low, high bounds, four attributes
// - Overlap: lowest matching index wins
// - Inclusive match on 34-bit padded bounds
// - Fetch from I/O faults, code 1
// - No speculative access to I/O
// - Misaligned I/O load 5, store 7
// - Modifiable I/O load 5, store 7
// - Stack push/pop to I/O faults
// - Split misaligned store counts as modified
// - Bufferable sets type bit 0, stores only
// - Bufferable stores use write buffer
// - Cacheable sets type bit 1
// - Load-reserved to non-atomic region faults 5
// - SC or AMO to non-atomic faults 7
// - Atomic attribute checked only with atomics
// - No regions: main, atomics allowed
// - Uncovered address: I/O, no atomics
// - Every access checked, never disabled
// - Memory type travels with valid
module pmac_check
	import pmac_pkg::*;
#(
	parameter int              NUM_REGIONS       = 0,
	parameter bit              ATOMIC_EXT_ENABLE = 1'b0,
	parameter bit              COPROC_EXT_ENABLE = 1'b0,
	parameter pmac_region_type [`PMAC_MAX_REGIONS-1:0] REGION_CFG = '0
)
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rstn,
	// Fetch stage
	input  wire pmac_fetch_req_type fetchReq,
	output pmac_fetch_rsp_type      fetchRsp,
	// Load-store stage
	input  wire pmac_lsu_req_type   lsuReq,
	output pmac_lsu_rsp_type        lsuRsp,
	// Avalon-MM slave
	input  wire logic [4:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest
);

	pmac_state_type stQ;
	pmac_state_type stD;
	pmac_attr_type  fetchAttr;
	pmac_attr_type  lsuAttr;
	pmac_attr_type  probeAttr;
	logic           misaligned;
	logic           splitAcc;
	logic           modified;
	logic           ioFault;
	logic           atomFault;
	logic           lsuFault;
	logic           isLoadCode;
	logic           lsuBuf;
	logic           busTaken;
	logic           anyFault;

	// Lowest index is scanned last so it overwrites higher hits
	function automatic pmac_attr_type lookup(input logic [31:0] a);
		pmac_attr_type r;
		logic [33:0]   x;
		x = {`PMAC_ADDR_PAD, a};
		if (NUM_REGIONS == 0)
		begin
			r = `PMAC_ATTR_NOREGION;
		end
		else
		begin
			r = `PMAC_ATTR_UNMAPPED;
		end
		for (int i = `PMAC_MAX_REGIONS - 1; i >= 0; i--)
		begin
			if ((i < NUM_REGIONS) &&
				(x >= {REGION_CFG[i].wordAddrLow, `PMAC_ADDR_PAD}) &&
				(x <= {REGION_CFG[i].wordAddrHigh, `PMAC_ADDR_PAD}))
			begin
				r.main       = REGION_CFG[i].main;
				r.bufferable = REGION_CFG[i].bufferable;
				r.cacheable  = REGION_CFG[i].cacheable;
				r.atomic     = REGION_CFG[i].atomic;
			end
		end
		return r;
	endfunction

	// Same-cycle lookups for fetch, load-store and probe
	assign fetchAttr = lookup(fetchReq.addr);
	assign lsuAttr   = lookup(lsuReq.addr);
	assign probeAttr = lookup(stQ.probeAddr);

	// Alignment classification of the data access
	assign misaligned = ((lsuReq.size == PMAC_SZ_HALF) && lsuReq.addr[0]) ||
		((lsuReq.size == PMAC_SZ_WORD) && (lsuReq.addr[1:0] != 2'h0));
	// A word off its boundary goes out as two subword transfers
	assign splitAcc = ((lsuReq.size == PMAC_SZ_WORD) &&
		(lsuReq.addr[1:0] != 2'h0)) ||
		((lsuReq.size == PMAC_SZ_HALF) && (lsuReq.addr[1:0] == 2'h3));
	assign modified = lsuReq.modifiable | splitAcc;

	// I/O refuses misaligned, modified and stack accesses
	assign ioFault = !lsuAttr.main &&
		(misaligned || modified || lsuReq.stack);
	// Atomic attribute only matters with the atomic extension
	assign atomFault = ATOMIC_EXT_ENABLE && !lsuAttr.atomic &&
		(lsuReq.atom != PMAC_AT_NONE);
	assign lsuFault = ioFault | atomFault;
	// LR and plain loads report the load code, the rest store/AMO
	assign isLoadCode = (lsuReq.atom == PMAC_AT_LR) ||
		((lsuReq.atom == PMAC_AT_NONE) && !lsuReq.write);
	// Only plain stores are bufferable
	assign lsuBuf = lsuAttr.bufferable && lsuReq.write &&
		(lsuReq.atom == PMAC_AT_NONE);
	assign anyFault = (fetchReq.valid && !fetchAttr.main) ||
		(lsuReq.valid && lsuFault);
	assign busTaken = (avs_read || avs_write) && stQ.waitReq;

	// Next state of the whole block
	always_comb
	begin
		stD = stQ;
		// Fetch checking cannot be switched off
		stD.fetchRsp.valid = fetchReq.valid;
		stD.fetchRsp.fault = fetchReq.valid && !fetchAttr.main;
		stD.fetchRsp.cause = (fetchReq.valid && !fetchAttr.main) ?
			`PMAC_CAUSE_INSTR : `PMAC_CAUSE_NONE;
		stD.lsuRsp.valid = lsuReq.valid;
		stD.lsuRsp.fault = lsuReq.valid && lsuFault;
		if (lsuReq.valid && lsuFault)
		begin
			stD.lsuRsp.cause = isLoadCode ?
				`PMAC_CAUSE_LOAD : `PMAC_CAUSE_STORE;
		end
		else
		begin
			stD.lsuRsp.cause = `PMAC_CAUSE_NONE;
		end
		// Type bits leave together with the valid
		stD.lsuRsp.memType[`PMAC_MT_BUF] = lsuReq.valid && lsuBuf;
		stD.lsuRsp.memType[`PMAC_MT_CACHE] = lsuReq.valid &&
			lsuAttr.cacheable;
		stD.lsuRsp.writeBuf = lsuReq.valid && lsuBuf && !lsuFault;
		// Non-idempotent space must not see a guess
		stD.lsuRsp.hold = lsuReq.valid && lsuReq.speculative &&
			!lsuAttr.main && !lsuFault;
		// Bus slave: one wait cycle, then a one-cycle answer
		stD.waitReq = !busTaken;
		if (busTaken && avs_read)
		begin
			unique case (avs_address)
				`PMAC_OFS_CAUSE:
					stD.readData = {23'h0, stQ.faultValid,
						3'h0, stQ.faultCause};
				`PMAC_OFS_FADDR: stD.readData = stQ.faultAddr;
				`PMAC_OFS_COUNT: stD.readData = {16'h0, stQ.faultCount};
				`PMAC_OFS_PROBE: stD.readData = stQ.probeAddr;
				`PMAC_OFS_PATTR: stD.readData = {28'h0, probeAttr};
				default:         stD.readData = `PMAC_RST_WORD;
			endcase
		end
		// Software writes land at the edge that ends the answer cycle,
		// where the master sees waitrequest low; capture below wins
		if (avs_write && !stQ.waitReq)
		begin
			unique case (avs_address)
				`PMAC_OFS_CAUSE:
				begin
					stD.faultValid = 1'b0;
					stD.faultCause = `PMAC_CAUSE_NONE;
				end
				`PMAC_OFS_COUNT: stD.faultCount = 16'h0;
				`PMAC_OFS_PROBE: stD.probeAddr = avs_writedata;
				default:         stD.probeAddr = stQ.probeAddr;
			endcase
		end
		// Capture latest fault; fetch reported if both hit
		if (lsuReq.valid && lsuFault)
		begin
			stD.faultValid = 1'b1;
			stD.faultCause = stD.lsuRsp.cause;
			stD.faultAddr  = lsuReq.addr;
		end
		if (fetchReq.valid && !fetchAttr.main)
		begin
			stD.faultValid = 1'b1;
			stD.faultCause = `PMAC_CAUSE_INSTR;
			stD.faultAddr  = fetchReq.addr;
		end
		// Counter saturates so software never sees a wrap
		if (anyFault && (stD.faultCount != 16'hffff))
		begin
			stD.faultCount = stD.faultCount + 16'h1;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			stQ         <= '0;
			stQ.waitReq <= 1'b1;
		end
		else
		begin
			stQ <= stD;
		end
	end

	// Outputs straight from the state register
	assign fetchRsp        = stQ.fetchRsp;
	assign lsuRsp          = stQ.lsuRsp;
	assign avs_readdata    = stQ.readData;
	assign avs_waitrequest = stQ.waitReq;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence ioLoadSeq;
		lsuReq.valid && !lsuAttr.main && !lsuReq.write &&
		(lsuReq.atom == PMAC_AT_NONE);
	endsequence

	sequence ioStoreSeq;
		lsuReq.valid && !lsuAttr.main && lsuReq.write &&
		(lsuReq.atom == PMAC_AT_NONE);
	endsequence

	sequence busAnswerSeq;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	fetch_io_fault_a: assert property (
		fetchReq.valid && !fetchAttr.main |=>
		fetchRsp.fault && (fetchRsp.cause == `PMAC_CAUSE_INSTR))
		else $error("fetch from I/O not refused");

	fetch_main_ok_a: assert property (
		fetchReq.valid && fetchAttr.main |=>
		fetchRsp.valid && !fetchRsp.fault)
		else $error("fetch from main memory faulted");

	misalign_load_a: assert property (
		ioLoadSeq and misaligned |=>
		lsuRsp.fault && (lsuRsp.cause == `PMAC_CAUSE_LOAD))
		else $error("misaligned I/O load not faulted");

	misalign_store_a: assert property (
		ioStoreSeq and misaligned |=>
		lsuRsp.fault && (lsuRsp.cause == `PMAC_CAUSE_STORE))
		else $error("misaligned I/O store not faulted");

	modified_io_a: assert property (
		ioStoreSeq and lsuReq.modifiable |=>
		lsuRsp.fault && !lsuRsp.writeBuf)
		else $error("modifiable I/O store not faulted");

	split_store_a: assert property (
		ioStoreSeq and (lsuReq.size == PMAC_SZ_WORD) and
		(lsuReq.addr[1:0] == 2'h2) |=>
		lsuRsp.fault)
		else $error("split word store to I/O passed");

	stack_io_a: assert property (
		lsuReq.valid && !lsuAttr.main && lsuReq.stack |=>
		lsuRsp.fault && (lsuRsp.cause != `PMAC_CAUSE_NONE))
		else $error("stack access to I/O passed");

	spec_hold_a: assert property (
		lsuReq.valid && lsuReq.speculative && !lsuAttr.main |=>
		(lsuRsp.hold || lsuRsp.fault))
		else $error("speculative I/O access not held");

	buf_type_a: assert property (
		lsuReq.valid && !lsuReq.write |=>
		!lsuRsp.memType[`PMAC_MT_BUF] && !lsuRsp.writeBuf)
		else $error("load marked bufferable");

	cache_type_a: assert property (
		lsuReq.valid |=>
		lsuRsp.memType[`PMAC_MT_CACHE] == $past(lsuAttr.cacheable))
		else $error("cacheable bit wrong");

	lr_atomic_a: assert property (
		lsuReq.valid && ATOMIC_EXT_ENABLE && !lsuAttr.atomic &&
		(lsuReq.atom == PMAC_AT_LR) |=>
		lsuRsp.fault && (lsuRsp.cause == `PMAC_CAUSE_LOAD))
		else $error("LR to non-atomic region passed");

	amo_atomic_a: assert property (
		lsuReq.valid && ATOMIC_EXT_ENABLE && !lsuAttr.atomic &&
		(lsuReq.atom inside {PMAC_AT_SC, PMAC_AT_AMO}) |=>
		lsuRsp.fault && (lsuRsp.cause == `PMAC_CAUSE_STORE))
		else $error("SC or AMO to non-atomic region passed");

	bus_answer_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> busAnswerSeq)
		else $error("bus request not answered in one cycle");

	fault_count_a: assert property (
		anyFault && (stQ.faultCount < 16'hfffe) |=>
		stQ.faultCount != 16'h0)
		else $error("fault not counted");

	sequence lsuFaultSeq;
		lsuReq.valid && lsuFault;
	endsequence

	load_code_a: assert property (
		lsuFaultSeq and !lsuReq.write |=>
		lsuRsp.cause == `PMAC_CAUSE_LOAD)
		else $error("faulting load reported a store code");

	store_code_a: assert property (
		lsuFaultSeq and lsuReq.write and (lsuReq.atom != PMAC_AT_LR) |=>
		lsuRsp.cause == `PMAC_CAUSE_STORE)
		else $error("faulting store reported a load code");

	fault_flag_a: assert property (
		anyFault |=> stQ.faultValid)
		else $error("fault not captured");

	main_ok_a: assert property (
		lsuReq.valid && lsuAttr.main && lsuAttr.atomic |=> !lsuRsp.fault)
		else $error("access to main memory faulted");

	atom_off_a: assert property (
		!ATOMIC_EXT_ENABLE && lsuReq.valid && lsuAttr.main |=>
		!lsuRsp.fault)
		else $error("atomic attribute used without the extension");

	no_region_a: assert property (
		(NUM_REGIONS == 0) |->
		(lsuAttr == `PMAC_ATTR_NOREGION) &&
		(fetchAttr == `PMAC_ATTR_NOREGION))
		else $error("deconfigured map not main with atomics");

	wbuf_store_a: assert property (
		lsuReq.valid && lsuReq.write && lsuAttr.bufferable &&
		(lsuReq.atom == PMAC_AT_NONE) && !lsuFault |=> lsuRsp.writeBuf)
		else $error("bufferable store bypassed the write buffer");

	atom_unbuf_a: assert property (
		lsuReq.valid && (lsuReq.atom != PMAC_AT_NONE) |=>
		!lsuRsp.memType[`PMAC_MT_BUF] && !lsuRsp.writeBuf)
		else $error("atomic access marked bufferable");

	type_idle_a: assert property (
		!lsuReq.valid |=> !lsuRsp.valid && (lsuRsp.memType == 2'h0))
		else $error("memory type driven without valid");

	lsu_valid_a: assert property (
		lsuReq.valid |=> lsuRsp.valid)
		else $error("load-store request not answered next cycle");

	fetch_idle_a: assert property (
		!fetchReq.valid |=> !fetchRsp.valid && !fetchRsp.fault)
		else $error("fetch answer without a request");

	bus_idle_a: assert property (
		!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without a request");

endmodule // pmac_check

// ### verif/pmac_stage_model.sv
`timescale 1ns/10ps
module pmac_stage_model
	import pmac_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rstn,
	// Requests handed over by the bench
	input  wire logic               go,
	input  wire pmac_fetch_req_type fetchNext,
	input  wire pmac_lsu_req_type   lsuNext,
	// Stage requests towards the checker
	output pmac_fetch_req_type      fetchReq,
	output pmac_lsu_req_type        lsuReq
);
	// One request per go; idle addresses keep toggling so none looks stale
	always_ff @(posedge clock or negedge rstn)
		if (!rstn)
		begin
			fetchReq <= '0;
			lsuReq <= '0;
		end
		else if (go)
		begin
			fetchReq <= fetchNext;
			lsuReq <= lsuNext;
		end
		else
		begin
			fetchReq <= '{valid: 1'b0, addr: ~fetchReq.addr};
			lsuReq.valid <= 1'b0;
			lsuReq.addr <= ~lsuReq.addr;
		end
endmodule // pmac_stage_model

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import pmac_pkg::*;
	// Stimulus of both stages beside the expected answer
	typedef struct {
		logic [31:0] fa;
		logic        ff;
		logic [31:0] a;
		logic        wr;
		logic [1:0]  sz;
		logic [1:0]  at;
		logic        st;
		logic        md;
		logic        sp;
		logic        flt;
		logic [4:0]  cs;
		logic [1:0]  mt;
		logic        wb;
		logic        hd;
	} pmac_row_type;
	// Region 0 main, all set; 1 I/O overlapping 0; 2 main, no atomics
	localparam pmac_region_type R0 = {32'h0000_0100, 32'h0000_01ff, 4'hf};
	localparam pmac_region_type R1 = {32'h0000_0180, 32'h0000_02ff, 4'h4};
	localparam pmac_region_type R2 = {32'h0000_0400, 32'h0000_04ff, 4'ha};
	localparam pmac_region_type [15:0] CFG = {{13{68'h0}}, R2, R1, R0};
	logic               clock;
	logic               rstn;
	logic               go;
	pmac_fetch_req_type fetchNext;
	pmac_fetch_req_type fetchReq;
	pmac_fetch_rsp_type fetchRsp;
	pmac_fetch_rsp_type fetchRsp0;
	pmac_lsu_req_type   lsuNext;
	pmac_lsu_req_type   lsuReq;
	pmac_lsu_rsp_type   lsuRsp;
	pmac_lsu_rsp_type   lsuRsp0;
	pmac_lsu_rsp_type   lsuRspA;
	logic [4:0]         avs_address;
	logic               avs_read;
	logic               avs_write;
	logic [31:0]        avs_writedata;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic [31:0]        rd;
	int                 failures;
	int                 n_checks;
	int                 cycles;
	pmac_row_type       rows[$];

	pmac_stage_model pmac_stage_model_i (.clock(clock), .rstn(rstn),
		.go(go), .fetchNext(fetchNext), .lsuNext(lsuNext),
		.fetchReq(fetchReq), .lsuReq(lsuReq));
	// Configured checker; coprocessor option off, a parameter the checker never reads
	pmac_check #(.NUM_REGIONS(3), .ATOMIC_EXT_ENABLE(1'b1),
		.COPROC_EXT_ENABLE(1'b0), .REGION_CFG(CFG)) pmac_check_i (
		.clock(clock), .rstn(rstn), .fetchReq(fetchReq),
		.fetchRsp(fetchRsp), .lsuReq(lsuReq), .lsuRsp(lsuRsp),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	// Deconfigured checker sees the same traffic
	pmac_check #(.NUM_REGIONS(0), .ATOMIC_EXT_ENABLE(1'b1))
		pmac_check_bare_i (.clock(clock), .rstn(rstn),
		.fetchReq(fetchReq), .fetchRsp(fetchRsp0), .lsuReq(lsuReq),
		.lsuRsp(lsuRsp0), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(),
		.avs_waitrequest());
	// Same map without the atomic extension: atomic bit ignored
	pmac_check #(.NUM_REGIONS(3), .ATOMIC_EXT_ENABLE(1'b0),
		.REGION_CFG(CFG)) pmac_check_noat_i (.clock(clock),
		.rstn(rstn), .fetchReq(fetchReq), .fetchRsp(),
		.lsuReq(lsuReq), .lsuRsp(lsuRspA), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(),
		.avs_waitrequest());

	// Clock and hang guard
	always #20 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Present one row; the answer stands one cycle after the stage edge
	task automatic run(pmac_row_type r);
		@(posedge clock);
		go <= 1'b1;
		fetchNext <= '{valid: 1'b1, addr: r.fa};
		lsuNext <= '{1'b1, r.a, r.wr, pmac_size_type'(r.sz),
			pmac_atom_type'(r.at), r.st, r.md, r.sp};
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		#1;
	endtask

	// Avalon transfer: hold until waitrequest is seen low at an edge
	task automatic av(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		while (w && n < 20)
		begin
			// Sampled at the rising edge, before it updates the slave
			@(posedge clock);
			w = avs_waitrequest;
			q = avs_readdata;
			n++;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk("avalon answer", 0, w);
		@(posedge clock);
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// fa ff a wr sz at st md sp flt cs mt wb hd
	initial
	begin
		rows = '{'{'h400,0,'h400,0,2,0,0,0,0,0,0,2,0,0},
			'{'h600,0,'h600,1,2,0,0,0,0,0,0,3,1,0},
			'{'h800,1,'h800,1,2,0,0,0,0,0,0,1,1,0},
			'{'h1000,0,'h802,0,2,0,0,0,0,1,5,0,0,0},
			'{'h3fc,1,'h803,1,1,0,0,0,0,1,7,0,0,0},
			'{'h7fc,0,'h800,0,0,0,0,1,0,1,5,0,0,0},
			'{'h7fd,1,'h804,1,2,0,0,1,0,1,7,0,0,0},
			'{'h13fc,0,'h804,0,2,0,1,0,0,1,5,0,0,0},
			'{'h13fd,1,'h808,1,2,0,1,0,0,1,7,0,0,0},
			'{'h2000,1,'h808,0,2,0,0,0,1,0,0,0,0,1},
			'{'h400,0,'h400,0,2,0,0,0,1,0,0,2,0,0},
			'{'h400,0,'h404,1,2,0,1,1,0,0,0,3,1,0},
			'{'h400,0,'h1000,0,2,1,0,0,0,1,5,0,0,0},
			'{'h400,0,'h1000,1,2,2,0,0,0,1,7,0,0,0},
			'{'h400,0,'h1000,1,2,3,0,0,0,1,7,0,0,0},
			'{'h400,0,'h400,0,2,1,0,0,0,0,0,2,0,0},
			'{'h400,0,'h400,1,2,3,0,0,0,0,0,2,0,0},
			'{'h400,0,'h600,1,2,2,0,0,0,0,0,2,0,0},
			'{'h400,0,'h402,0,2,0,0,0,0,0,0,2,0,0},
			'{'h400,0,'h7fd,0,0,0,0,0,0,0,0,0,0,0},
			'{'h400,0,'h13fc,0,2,0,0,0,0,0,0,2,0,0},
			'{'h400,0,'h13fd,0,0,0,0,0,0,0,0,0,0,0},
			'{'h400,0,'h2000,1,2,2,0,0,0,1,7,0,0,0},
			'{'h400,0,'h2000,1,2,0,0,0,0,0,0,0,0,0}};
		{clock, rstn, go, avs_read, avs_write} = '0;
		{fetchNext, lsuNext, avs_address, avs_writedata} = '0;
		{failures, n_checks, cycles} = '0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		av(0, 5'h00, 0, rd);
		chk("cause at reset", 0, rd);
		foreach (rows[i])
		begin
			run(rows[i]);
			chk("fetch valid", 1, fetchRsp.valid);
			chk("fetch fault", rows[i].ff, fetchRsp.fault);
			chk("fetch cause", rows[i].ff, fetchRsp.cause);
			chk("lsu valid", 1, lsuRsp.valid);
			chk("lsu fault", rows[i].flt, lsuRsp.fault);
			chk("lsu cause", rows[i].cs, lsuRsp.cause);
			if (!rows[i].flt)
				chk("mem type", rows[i].mt, lsuRsp.memType);
			chk("write buf", rows[i].wb, lsuRsp.writeBuf);
			chk("hold", rows[i].hd, lsuRsp.hold);
			chk("bare fault", 0, lsuRsp0.fault | fetchRsp0.fault);
			chk("bare type", 0, lsuRsp0.memType);
			if (rows[i].at != 0)
				chk("no atomics fault", 0, lsuRspA.fault);
		end
		@(posedge clock);
		#1;
		chk("valid drop", 0, lsuRsp.valid | fetchRsp.valid);
		$display("test rows done");
		// Fault capture, probe lookup and an unmapped address
		av(1, 5'h00, 0, rd);
		av(1, 5'h08, 0, rd);
		run(rows[3]);
		av(0, 5'h00, 0, rd);
		chk("cause", 'h105, rd);
		av(0, 5'h04, 0, rd);
		chk("fault addr", 'h802, rd);
		av(0, 5'h08, 0, rd);
		chk("count", 1, rd);
		av(1, 5'h0c, 'h600, rd);
		av(0, 5'h10, 0, rd);
		chk("probe attr", 'hf, rd);
		av(1, 5'h0c, 'h2000, rd);
		av(0, 5'h10, 0, rd);
		chk("probe attr", 0, rd);
		av(0, 5'h14, 0, rd);
		chk("unmapped", 0, rd);
		$display("test registers done");
		// Reset in mid-run, then traffic again
		rstn <= 1'b0;
		@(posedge clock);
		#1;
		chk("reset wait", 1, avs_waitrequest);
		chk("reset rsp", 0, lsuRsp.valid | fetchRsp.valid);
		@(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		chk("wait after release", 1, avs_waitrequest);
		run(rows[1]);
		chk("after reset", 3, lsuRsp.memType);
		chk("after reset buf", 1, lsuRsp.writeBuf);
		$display("test reset done");
		give_verdict();
	end
endmodule // tb_top
